// >>> logic/msc_config_top.sv
// Purpose: address decode, interrupt routing and driver enables of a multi-port serial card
// Assumes: switch and jumper inputs are static; host address is from the same clock domain
// Notes:   decode outputs are combinational; the status byte is registered
`timescale 1ns/1ns
`default_nettype none
module msc_config_top #(
  parameter int unsigned NUM_PORTS = 8,
  parameter bit          HAS_A9_SW = 1'b1,
  parameter bit          HAS_IRQ_SW = 1'b1,
  parameter bit          MIXED_VARIANT = 1'b0
) (
  input  wire logic                                  clk,
  input  wire logic                                  sys_rst,
  // host bus
  input  wire logic [mscfg_pkg::ADDR_W-1:0]          hostAddr,
  input  wire logic                                  hostAen,
  input  wire logic                                  hostIorN,
  output logic [NUM_PORTS-1:0]                       portSelect,
  output logic                                       statSelect,
  output logic [7:0]                                 statData,
  output logic                                       statDataOeN,
  // switch banks, raw pins
  input  wire logic [mscfg_pkg::SEL_W-1:0]           port_base_switch_bank,
  input  wire logic [mscfg_pkg::SEL_W-1:0]           card_option_switch_bank_b,
  input  wire logic                                  enhancedModeSw,
  input  wire logic                                  sharedIrqSw,
  input  wire logic                                  highSpeedSw,
  input  wire logic [3:0]                            shared_irq_jumper_bank,
  input  wire logic [NUM_PORTS*4-1:0]                portIrqJumper,
  input  wire logic [NUM_PORTS*2-1:0]                drvModeJumper,
  input  wire logic [NUM_PORTS-1:0]                  txCtrlJumperClosed,
  // port side
  input  wire logic [NUM_PORTS-1:0]                  uartIrq,
  input  wire logic [NUM_PORTS-1:0]                  uartTxActive,
  input  wire logic [NUM_PORTS-1:0]                  uartRts,
  output logic [NUM_PORTS-1:0]                       lineDrvEn,
  output logic [mscfg_pkg::IRQ_LINES-1:0]            hostIrq,
  output logic                                       highSpeed
);
  import mscfg_pkg::*;

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // window generator and status byte serve four or eight ports only
  if (NUM_PORTS != STD_PORTS && NUM_PORTS != MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must be 4 or 8");
  end
  // transmit jumpers exist only on the four-port mixed card
  if (MIXED_VARIANT && NUM_PORTS != STD_PORTS) begin : g_bad_mixed
    $error("MIXED_VARIANT needs four ports");
  end
  // switch field must reach from the window size up to the top address line
  if (WIN_LSB + SEL_W != ADDR_W || A9_BIT >= SEL_W) begin : g_bad_field
    $error("switch field does not span the address");
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // switches sit on pins; two stages each before use
  localparam int unsigned SW_W = 2*SEL_W + 3 + 4 + NUM_PORTS*7;
  logic [SW_W-1:0] swMeta_r;
  logic [SW_W-1:0] swSync_r;
  logic [NUM_PORTS-1:0] irqMeta_r;
  logic [NUM_PORTS-1:0] irqSync_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      swMeta_r <= '0;
      swSync_r <= '0;
    end else begin
      swMeta_r <= {port_base_switch_bank, card_option_switch_bank_b, enhancedModeSw,
                   sharedIrqSw, highSpeedSw, shared_irq_jumper_bank, portIrqJumper,
                   drvModeJumper, txCtrlJumperClosed};
      swSync_r <= swMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // interrupt request synchroniser
  // ----------------------------------------------------------------
  // uart requests follow their own timing, so two stages here as well
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqMeta_r <= '0;
      irqSync_r <= '0;
    end else begin
      irqMeta_r <= uartIrq;
      irqSync_r <= irqMeta_r;
    end
  end

  logic [SEL_W-1:0]       portSel;
  logic [SEL_W-1:0]       statSel;
  logic                   enhMode;
  logic                   shareMode;
  logic [3:0]             shareIrq;
  logic [NUM_PORTS*4-1:0] portIrqSel;
  logic [NUM_PORTS*2-1:0] drvModeSel;
  logic [NUM_PORTS-1:0]   txJmp;
  logic                   hsSw;

  // field offsets inside the synchroniser word, lowest field first
  localparam int unsigned OFS_TXJ = 0;
  localparam int unsigned OFS_DRV = OFS_TXJ + NUM_PORTS;
  localparam int unsigned OFS_PIQ = OFS_DRV + NUM_PORTS*2;
  localparam int unsigned OFS_SIQ = OFS_PIQ + NUM_PORTS*4;
  localparam int unsigned OFS_HS  = OFS_SIQ + 4;
  localparam int unsigned OFS_SHR = OFS_HS + 1;
  localparam int unsigned OFS_ENH = OFS_SHR + 1;
  localparam int unsigned OFS_STA = OFS_ENH + 1;
  localparam int unsigned OFS_PRT = OFS_STA + SEL_W;

  assign txJmp      = swSync_r[OFS_TXJ +: NUM_PORTS];
  assign drvModeSel = swSync_r[OFS_DRV +: NUM_PORTS*2];
  assign portIrqSel = swSync_r[OFS_PIQ +: NUM_PORTS*4];
  assign shareIrq   = swSync_r[OFS_SIQ +: 4];
  assign hsSw       = swSync_r[OFS_HS];
  assign shareMode  = swSync_r[OFS_SHR];
  assign enhMode    = swSync_r[OFS_ENH];
  assign statSel    = swSync_r[OFS_STA +: SEL_W];
  assign portSel    = swSync_r[OFS_PRT +: SEL_W];

  // ----------------------------------------------------------------
  // settings in force (shipped values during reset)
  // ----------------------------------------------------------------
  logic              cfgValid_r;
  logic [SEL_W-1:0]  portSelEff;
  logic [SEL_W-1:0]  statSelEff;
  logic              enhEff;
  logic              shareEff;
  logic [3:0]        shareIrqEff;

  // synchroniser output is not trusted until three edges after reset release
  logic [1:0] cfgCnt_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfgCnt_r   <= 2'h0;
      cfgValid_r <= 1'b0;
    end else if (cfgCnt_r != 2'(CFG_SETTLE)) begin
      cfgCnt_r   <= cfgCnt_r + 2'h1;
    end else begin
      cfgValid_r <= 1'b1;
    end
  end

  always_comb begin
    if (!cfgValid_r) begin
      portSelEff  = DEF_PORT_SEL;
      statSelEff  = DEF_STAT_SEL;
      enhEff      = 1'b1;
      shareEff    = 1'b1;
      shareIrqEff = DEF_SHARE_IRQ;
    end else begin
      portSelEff  = portSel;
      statSelEff  = statSel;
      enhEff      = enhMode;
      shareEff    = HAS_IRQ_SW ? shareMode : 1'b1;
      shareIrqEff = shareIrq;
    end
    if (!HAS_A9_SW) begin
      portSelEff[A9_BIT] = 1'b1;
      statSelEff[A9_BIT] = 1'b1;
    end
  end

  assign highSpeed = cfgValid_r ? hsSw : DEF_HIGH_SPD;

  // ----------------------------------------------------------------
  // driver enable mode per port
  // ----------------------------------------------------------------
  msc_drv_mode_t drvMode [NUM_PORTS];

  // the mixed card has a two-state jumper only; others take the full code
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (MIXED_VARIANT) begin
        drvMode[p] = txJmp[p] ? MSC_EN_AUTO : MSC_EN_ON;
      end else begin
        drvMode[p] = msc_drv_mode_t'(drvModeSel[p*2 +: 2]);
      end
    end
  end

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] stdAddr [STD_PORTS];
  assign stdAddr[0] = STD_ADDR0;
  assign stdAddr[1] = STD_ADDR1;
  assign stdAddr[2] = STD_ADDR2;
  assign stdAddr[3] = STD_ADDR3;

  logic [ADDR_W-1:0]    cardBase;
  logic [NUM_PORTS-1:0] winHit;
  logic                 statHit;
  logic                 ioCycle;

  // A3..A9 weights sum to the base; low bits always zero
  assign cardBase = {portSelEff, 3'h0};
  assign ioCycle  = !hostAen;                    // dma cycles never decode

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      logic [ADDR_W-1:0] winBase;
      if (gi < STD_PORTS) begin : g_std
        assign winBase = enhEff ? ADDR_W'(cardBase + ADDR_W'(gi << WIN_LSB))
                                : stdAddr[gi];
      end else begin : g_ext
        assign winBase = ADDR_W'(cardBase + ADDR_W'(gi << WIN_LSB));
      end
      msc_win_match u_match (
        .hostAddr (hostAddr),
        .winBase  (winBase),
        .hit      (winHit[gi])
      );
      // ports above four have no standard address
      assign portSelect[gi] = ioCycle && winHit[gi] &&
                              (enhEff || gi < STD_PORTS);

      msc_drv_enable u_drv (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .mode     (drvMode[gi]),
        .txActive (uartTxActive[gi]),
        .rtsOut   (uartRts[gi]),
        .drvEn    (lineDrvEn[gi])
      );
    end
  endgenerate

  msc_win_match u_stat (
    .hostAddr (hostAddr),
    .winBase  ({statSelEff, 3'h0}),
    .hit      (statHit)
  );
  // status register only exists while ports share a request
  assign statSelect = ioCycle && statHit && enhEff && shareEff;

  // ----------------------------------------------------------------
  // interrupt status register
  // ----------------------------------------------------------------
  logic [7:0] stat_r;
  logic [7:0] stat_nxt;
  always_comb begin
    stat_nxt = 8'h0;
    stat_nxt[NUM_PORTS-1:0] = irqSync_r;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stat_r <= 8'h0;
    end else begin
      stat_r <= stat_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      statData <= 8'h0;
    end else begin
      statData <= stat_r;
    end
  end
  assign statDataOeN = !(statSelect && !hostIorN);

  // ----------------------------------------------------------------
  // interrupt routing
  // ----------------------------------------------------------------
  logic [3:0] stdIrqLine [STD_PORTS];
  assign stdIrqLine[0] = STD_IRQ_P1;
  assign stdIrqLine[1] = STD_IRQ_P2;
  assign stdIrqLine[2] = STD_IRQ_P3;
  assign stdIrqLine[3] = STD_IRQ_P4;

  logic [IRQ_LINES-1:0] stdIrqVec;
  logic [IRQ_LINES-1:0] indIrqVec;
  logic [IRQ_LINES-1:0] shrIrqVec;

  // standard mode: ports above four never reach the host
  always_comb begin
    stdIrqVec = '0;
    for (int p = 0; p < STD_PORTS; p++) begin
      stdIrqVec[stdIrqLine[p]] = stdIrqVec[stdIrqLine[p]] | stat_r[p];
    end
  end

  // independent: two ports jumpered to one line simply or together
  always_comb begin
    indIrqVec = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      indIrqVec[portIrqSel[p*4 +: 4]] =
        indIrqVec[portIrqSel[p*4 +: 4]] | stat_r[p];
    end
  end

  always_comb begin
    shrIrqVec              = '0;
    shrIrqVec[shareIrqEff] = |stat_r;
  end

  always_comb begin
    if (!enhEff) begin
      hostIrq = stdIrqVec;
    end else if (shareEff) begin
      hostIrq = shrIrqVec;
    end else begin
      hostIrq = indIrqVec;
    end
  end
endmodule
`default_nettype wire

// >>> logic/mscfg_pkg.sv
// Purpose: constants for the multi-port serial card configuration logic
// Assumes: ten-bit host I/O address, four or eight UART windows of eight bytes
// Notes:   switch banks are static levels
package mscfg_pkg;
  localparam int unsigned ADDR_W        = 10;
  localparam int unsigned WIN_LSB       = 3;   // eight-byte window
  localparam int unsigned SEL_W         = 7;   // A3..A9 switch field
  localparam int unsigned IRQ_LINES     = 16;
  localparam int unsigned MAX_PORTS     = 8;
  localparam int unsigned STD_PORTS     = 4;
  localparam logic [9:0]  STD_ADDR0     = 10'h3f8;
  localparam logic [9:0]  STD_ADDR1     = 10'h2f8;
  localparam logic [9:0]  STD_ADDR2     = 10'h3e8;
  localparam logic [9:0]  STD_ADDR3     = 10'h2e8;
  localparam logic [3:0]  STD_IRQ_P1    = 4'h4;
  localparam logic [3:0]  STD_IRQ_P2    = 4'h3;
  localparam logic [3:0]  STD_IRQ_P3    = 4'h4;
  localparam logic [3:0]  STD_IRQ_P4    = 4'h3;
  localparam logic [6:0]  DEF_PORT_SEL  = 7'h60;  // 300h >> 3
  localparam logic [6:0]  DEF_STAT_SEL  = 7'h50;  // 280h >> 3
  localparam logic [3:0]  DEF_SHARE_IRQ = 4'hc;   // line 12
  localparam logic        DEF_HIGH_SPD  = 1'b0;   // 1x
  localparam int unsigned A9_BIT        = 6;      // position of A9 in the switch field
  localparam int unsigned HOLD_CYC      = 4;      // driver hold after last tx activity
  localparam int unsigned CFG_SETTLE    = 2;      // edges counted before the edge that lets synchronised switches count

  typedef enum logic [1:0] {
    MSC_EN_AUTO,
    MSC_EN_RTS,
    MSC_EN_ON,
    MSC_EN_OFF
  } msc_drv_mode_t;
endpackage

// >>> logic/msc_win_match.sv
// Purpose: one eight-byte address window comparator
// Assumes: address and base are ten-bit host I/O values
// Notes:   purely combinational
`timescale 1ns/1ns
`default_nettype none
module msc_win_match (
  input  wire logic [mscfg_pkg::ADDR_W-1:0] hostAddr,
  input  wire logic [mscfg_pkg::ADDR_W-1:0] winBase,
  output logic                              hit
);
  import mscfg_pkg::*;
  // low three bits select the register inside the window
  assign hit = (hostAddr[ADDR_W-1:WIN_LSB] == winBase[ADDR_W-1:WIN_LSB]);
endmodule
`default_nettype wire

// >>> logic/msc_drv_enable.sv
// Purpose: line driver enable for one port
// Assumes: txActive is a same-clock level from the port's transmitter
// Notes:   auto mode holds the driver a few cycles past the last bit
`timescale 1ns/1ns
`default_nettype none
module msc_drv_enable (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire mscfg_pkg::msc_drv_mode_t mode,
  input  wire logic                     txActive,
  input  wire logic                     rtsOut,
  output logic                          drvEn
);
  import mscfg_pkg::*;
  logic [2:0] hold_r;

  // sense direction: keep the driver until the stop bit has left
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hold_r <= 3'h0;
    end else if (txActive) begin
      hold_r <= 3'(HOLD_CYC);
    end else if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end
  end

  always_comb begin
    unique case (mode)
      MSC_EN_AUTO: drvEn = txActive || (hold_r != 3'h0);
      MSC_EN_RTS:  drvEn = rtsOut;
      MSC_EN_ON:   drvEn = 1'b1;
      MSC_EN_OFF:  drvEn = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// >>> verification/msc_host_model.sv
// Purpose: host bus side of the serial card config block
// Assumes: one I/O cycle per clock, address held until the next cycle
// Notes:   the host always drives the address lines
`timescale 1ns/1ns
`default_nettype none
module msc_host_model (
  input  wire logic                         clk,
  output logic [mscfg_pkg::ADDR_W-1:0]      hostAddr,
  output logic                              hostAen,
  output logic                              hostIorN
);
  import mscfg_pkg::*;
  initial begin
    hostAddr = 10'h000;
    hostAen = 1'b0;
    hostIorN = 1'b1;
  end
  task automatic access(input logic [9:0] a, input logic aen, input logic rd);
    @(posedge clk);
    hostAddr <= a;
    hostAen <= aen;
    hostIorN <= ~rd;
  endtask
endmodule
`default_nettype wire

// >>> verification/msc_config_asserts.sv
// Purpose: port checks of the serial card config block
// Assumes: switches change only while sys_rst is high
// Notes:   most checks wait until switch values are live
`timescale 1ns/1ns
`default_nettype none
module msc_config_asserts #(
  parameter int unsigned NUM_PORTS = 8
) (
  input wire logic                            clk,
  input wire logic                            sys_rst,
  input wire logic [mscfg_pkg::ADDR_W-1:0]    hostAddr,
  input wire logic                            hostAen,
  input wire logic [NUM_PORTS-1:0]            portSelect,
  input wire logic                            statSelect,
  input wire logic [7:0]                      statData,
  input wire logic [mscfg_pkg::SEL_W-1:0]     port_base_switch_bank,
  input wire logic [mscfg_pkg::SEL_W-1:0]     card_option_switch_bank_b,
  input wire logic                            enhancedModeSw,
  input wire logic                            sharedIrqSw,
  input wire logic [3:0]                      shared_irq_jumper_bank,
  input wire logic [NUM_PORTS*2-1:0]          drvModeJumper,
  input wire logic [NUM_PORTS-1:0]            uartIrq,
  input wire logic [NUM_PORTS-1:0]            uartTxActive,
  input wire logic [NUM_PORTS-1:0]            uartRts,
  input wire logic [NUM_PORTS-1:0]            lineDrvEn,
  input wire logic [mscfg_pkg::IRQ_LINES-1:0] hostIrq
);
  import mscfg_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [2:0] liveCnt_r;
  logic       live;
  // shipped settings rule for a few edges after reset
  always_ff @(posedge clk) begin
    if (sys_rst) liveCnt_r <= 3'h0;
    else if (liveCnt_r != 3'h7) liveCnt_r <= liveCnt_r + 3'h1;
  end
  assign live = (liveCnt_r > 3'h4);
  sequence s_txQuiet; !uartTxActive[0] [*8]; endsequence
  sequence s_irqHeld; uartIrq[2] [*6]; endsequence
  a_dma_no_select: assert property (hostAen |-> portSelect == '0 && !statSelect)
    else $error("select during dma cycle");
  a_std_first_port: assert property (live && !enhancedModeSw && !hostAen && hostAddr[9:3] == 7'h7f |-> portSelect[0])
    else $error("standard port one missed");
  a_base_next_port: assert property (live && enhancedModeSw && !hostAen && hostAddr[9:3] == port_base_switch_bank + 7'h1 |-> portSelect[1])
    else $error("second port window missed");
  a_stat_mode_gate: assert property (live && statSelect |-> enhancedModeSw && sharedIrqSw)
    else $error("status select outside shared mode");
  a_stat_window_hit: assert property (live && enhancedModeSw && sharedIrqSw && !hostAen && hostAddr[9:3] == card_option_switch_bank_b |-> statSelect)
    else $error("status window missed");
  a_rts_driver_follow: assert property (live && drvModeJumper[3:2] == 2'h1 |-> lineDrvEn[1] == uartRts[1])
    else $error("rts driver enable wrong");
  a_on_driver_held: assert property (live && drvModeJumper[5:4] == 2'h2 |-> lineDrvEn[2])
    else $error("always-on driver dropped");
  a_auto_tx_on: assert property (live && drvModeJumper[1:0] == 2'h0 && uartTxActive[0] |-> lineDrvEn[0])
    else $error("auto driver off while sending");
  a_auto_quiet_off: assert property (live && drvModeJumper[1:0] == 2'h0 ##0 s_txQuiet |-> !lineDrvEn[0])
    else $error("auto driver stuck on");
  a_status_bit_set: assert property (live ##0 s_irqHeld |-> statData[2])
    else $error("status bit of port three missing");
  a_shared_line_up: assert property (live && enhancedModeSw && sharedIrqSw ##0 s_irqHeld |-> hostIrq[shared_irq_jumper_bank])
    else $error("shared request line idle");
endmodule
bind msc_config_top msc_config_asserts #(.NUM_PORTS(NUM_PORTS)) msc_config_asserts_inst (
  .clk, .sys_rst, .hostAddr, .hostAen, .portSelect, .statSelect, .statData,
  .port_base_switch_bank, .card_option_switch_bank_b, .enhancedModeSw, .sharedIrqSw,
  .shared_irq_jumper_bank, .drvModeJumper, .uartIrq, .uartTxActive, .uartRts, .lineDrvEn, .hostIrq
);
`default_nettype wire

// >>> verification/msc_config_top_bench.sv
// Purpose: self-checking bench of the serial card config block
// Assumes: switches change only while reset is held
// Notes:   decode is sampled mid-cycle, after the host model moves
`timescale 1ns/1ns
`default_nettype none
module msc_config_top_bench;
  import mscfg_pkg::*;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [9:0]  hostAddr;
  logic        hostAen;
  logic        hostIorN;
  logic [7:0]  portSelect;
  logic        statSelect;
  logic [7:0]  statData;
  logic        statDataOeN;
  logic [6:0]  port_base_switch_bank = 7'h40;
  logic [6:0]  card_option_switch_bank_b = 7'h4a;
  logic        enhancedModeSw = 1'b1;
  logic        sharedIrqSw = 1'b1;
  logic        highSpeedSw = 1'b1;
  logic [3:0]  shared_irq_jumper_bank = 4'h5;
  logic [31:0] portIrqJumper = 32'hfedcba98;
  logic [15:0] drvModeJumper = 16'hffe4;
  logic [7:0]  txCtrlJumperClosed = 8'h00;
  logic [7:0]  uartIrq = 8'h00;
  logic [7:0]  uartTxActive = 8'h00;
  logic [7:0]  uartRts = 8'h00;
  logic [7:0]  lineDrvEn;
  logic [15:0] hostIrq;
  logic        highSpeed;
  int          err_count = 0;
  int          samples_checked = 0;
  logic [9:0]  a9Addr = 10'h000;
  logic [3:0]  a9PortSelect;
  logic        a9StatSelect;
  logic [3:0]  a9TxActive = 4'h0;
  logic [3:0]  a9DrvEn;
  msc_config_top #(.NUM_PORTS(8)) msc_config_top_inst (
    .clk, .sys_rst, .hostAddr, .hostAen, .hostIorN, .portSelect, .statSelect, .statData,
    .statDataOeN, .port_base_switch_bank, .card_option_switch_bank_b, .enhancedModeSw,
    .sharedIrqSw, .highSpeedSw, .shared_irq_jumper_bank, .portIrqJumper, .drvModeJumper,
    .txCtrlJumperClosed, .uartIrq, .uartTxActive, .uartRts, .lineDrvEn, .hostIrq, .highSpeed
  );
  msc_host_model msc_host_model_inst (.clk, .hostAddr, .hostAen, .hostIorN);
  // four-port mixed card without an A9 switch; its switches never change
  msc_config_top #(.NUM_PORTS(4), .HAS_A9_SW(1'b0), .HAS_IRQ_SW(1'b1), .MIXED_VARIANT(1'b1))
    msc_config_top_a9_inst (
    .clk, .sys_rst, .hostAddr(a9Addr), .hostAen(1'b0), .hostIorN(1'b1),
    .portSelect(a9PortSelect), .statSelect(a9StatSelect), .statData(), .statDataOeN(),
    .port_base_switch_bank(7'h20), .card_option_switch_bank_b(7'h10), .enhancedModeSw(1'b1),
    .sharedIrqSw(1'b1), .highSpeedSw(1'b0), .shared_irq_jumper_bank(4'h5),
    .portIrqJumper(16'h0000), .drvModeJumper(8'hff), .txCtrlJumperClosed(4'h5),
    .uartIrq(4'h0), .uartTxActive(a9TxActive), .uartRts(4'h0), .lineDrvEn(a9DrvEn),
    .hostIrq(), .highSpeed()
  );
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic probe(input logic [9:0] a, input logic aen, input logic rd);
    msc_host_model_inst.access(a, aen, rd);
    @(negedge clk);
  endtask
  // switches only move under reset, so no half-applied setting is seen
  task automatic cfg(input logic [6:0] base, input logic enh, input logic shr);
    @(posedge clk);
    sys_rst <= 1'b1;
    port_base_switch_bank <= base;
    enhancedModeSw <= enh;
    sharedIrqSw <= shr;
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  // request goes through a synchroniser, so allow it settle time
  task automatic irq(input logic [7:0] v);
    @(posedge clk);
    uartIrq <= v;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic t_defaults();
    probe(10'h30b, 1'b0, 1'b0);
    check(16'(portSelect), 16'h0002);
    probe(10'h285, 1'b0, 1'b0);
    check(16'(statSelect), 16'h0001);
    check(16'(highSpeed), 16'h0000);
    probe(10'h20d, 1'b0, 1'b0);
    check(16'(portSelect), 16'h0000);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (6) @(posedge clk);
    probe(10'h20d, 1'b0, 1'b0);
    check(16'(portSelect), 16'h0002);
    check(16'(highSpeed), 16'h0001);
    probe(10'h257, 1'b0, 1'b1);
    check(16'(statSelect), 16'h0001);
    check(16'(statDataOeN), 16'h0000);
  endtask
  task automatic t_multi(input logic [6:0] sel);
    cfg(sel, 1'b1, 1'b1);
    for (int n = 0; n < 8; n++) begin
      probe({sel, 3'(n)} + 10'(8 * n), 1'b0, 1'b0);
      check(16'(portSelect), 16'(1 << n));
    end
    probe({sel, 3'h0}, 1'b1, 1'b0);
    check(16'(portSelect), 16'h0000);
  endtask
  task automatic t_standard();
    logic [9:0] stdTbl [4];
    stdTbl = '{STD_ADDR0, STD_ADDR1, STD_ADDR2, STD_ADDR3};
    cfg(7'h60, 1'b0, 1'b1);
    for (int n = 0; n < 4; n++) begin
      probe(stdTbl[n] + 10'(n), 1'b0, 1'b0);
      check(16'(portSelect), 16'(1 << n));
    end
    probe(10'h250, 1'b0, 1'b1);
    check(16'(statSelect), 16'h0000);
    irq(8'h01);
    check(hostIrq, 16'h0001 << STD_IRQ_P1);
    irq(8'h02);
    check(hostIrq, 16'h0001 << STD_IRQ_P2);
    irq(8'h00);
  endtask
  task automatic t_shared();
    cfg(7'h60, 1'b1, 1'b1);
    irq(8'h25);
    check(hostIrq, 16'h0020);
    probe(10'h257, 1'b0, 1'b1);
    check(16'(statSelect), 16'h0001);
    check(16'(statData), 16'h0025);
    irq(8'h00);
    check(hostIrq, 16'h0000);
  endtask
  task automatic t_indep();
    cfg(7'h60, 1'b1, 1'b0);
    irq(8'h94);
    check(hostIrq, 16'h9400);
    probe(10'h250, 1'b0, 1'b1);
    check(16'(statSelect), 16'h0000);
    irq(8'h00);
  endtask
  task automatic t_drivers();
    @(posedge clk);
    uartRts <= 8'h02;
    uartTxActive <= 8'h01;
    @(negedge clk);
    check(16'(lineDrvEn), 16'h0007);
    @(posedge clk);
    uartRts <= 8'h00;
    uartTxActive <= 8'h00;
    repeat (8) @(negedge clk);
    check(16'(lineDrvEn), 16'h0004);
  endtask
  // switches leave A9 low; the windows must still land at 300h and 280h
  task automatic t_fixed();
    @(posedge clk);
    a9Addr <= 10'h308;
    @(negedge clk);
    check(16'(a9PortSelect), 16'h0002);
    @(posedge clk);
    a9Addr <= 10'h285;
    @(negedge clk);
    check(16'(a9StatSelect), 16'h0001);
    check(16'(a9DrvEn), 16'h000a);
    @(posedge clk);
    a9TxActive <= 4'hf;
    @(negedge clk);
    check(16'(a9DrvEn), 16'h000f);
  endtask
  initial begin
    t_defaults();
    t_multi(7'h60);
    t_multi(7'h5f);
    t_standard();
    t_shared();
    t_indep();
    t_drivers();
    t_fixed();
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge clk);
    err_count++;
    finish_test();
  end
endmodule
`default_nettype wire
